// File: common/ocg_pkg.sv
/*
 Types shared by the output current fault guard.
 Assumes the command and sense inputs come from logic on clk_sys_i.
*/
package ocg_pkg;

    // ==========================================================
    // Fault handling states
    typedef enum logic [1:0] {
        OCG_RUN,
        OCG_LATCHED,
        OCG_RETRY_WAIT
    } ocg_state_t;

    // ==========================================================
    // Command request from the PMBus front end
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } ocg_cmd_t;

    // ==========================================================
    // Per-phase sense input, sample in amperes with fixed fraction
    typedef struct packed {
        logic pwm_on;
        logic smp_valid;
        logic signed [15:0] smp;
    } ocg_phase_in_t;

endpackage : ocg_pkg

// File: common/ocg_regs.svh
/*
 Command codes, field positions, reset values and timing figures of the
 output current fault guard. Assumes a 20 MHz system clock.
*/
`ifndef OCG_REGS_SVH
`define OCG_REGS_SVH

// ==========================================================
// Command codes
`define OCG_CMD_UC_ACTION 8'hE6
`define OCG_CMD_AVG_OC_LIM 8'hE7
`define OCG_CMD_AVG_UC_LIM 8'hE8

// ==========================================================
// Reset values
`define OCG_UC_ACTION_RST 8'h80
`define OCG_AVG_OC_LIM_RST 16'hDA80
`define OCG_AVG_UC_LIM_RST 16'hD580

// ==========================================================
// Fault action fields
`define OCG_BEHAV_HI 7
`define OCG_BEHAV_LO 6
`define OCG_RETRY_HI 5
`define OCG_RETRY_LO 3
`define OCG_BEHAV_SHUTDOWN 2'h2
`define OCG_RETRY_NONE 3'h0
`define OCG_RETRY_FOREVER 3'h7

// ==========================================================
// Linear-11 fields
`define OCG_L11_EXP_HI 15
`define OCG_L11_EXP_LO 11
`define OCG_L11_MAN_HI 10
`define OCG_L11_MAN_LO 0

// ==========================================================
// Current status bit positions
`define OCG_STAT_OC_BIT 7
`define OCG_STAT_UC_BIT 4

// ==========================================================
// Timing
`define OCG_CLK_KHZ 20000
`define OCG_RETRY_MS 70
`define OCG_BLANK_CYC 4
`define OCG_SMP_FRAC 4

`endif

// File: sim/ocg_sense_src.sv
/*
 Sense source model: drives the pwm windows and current samples of each phase.
 Assumes the guard samples these on rising edges of clk_sys_i.
*/
`include "ocg_regs.svh"

module ocg_sense_src #(
    parameter int NPH = 2,
    parameter int ON_CYC = 8,
    parameter int OFF_CYC = 12
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic sense_up_i,
    input wire logic signed [15:0] amps_i [NPH],
    output ocg_pkg::ocg_phase_in_t [NPH-1:0] phase_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // 100 A reading, far above the overcurrent limit, so a wrongly counted sample trips the upslope average
    localparam logic signed [15:0] SPIKE = 16'sh0640;
    int cnt_q;
    logic pwm_on;
    logic in_win;
    int win_pos;

    // ==========================================================
    // Switching period
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cnt_q <= 0;
        else
            cnt_q <= (cnt_q == ON_CYC + OFF_CYC - 1) ? 0 : cnt_q + 1;
    end

    assign pwm_on = (cnt_q < ON_CYC);
    assign in_win = sense_up_i ? pwm_on : !pwm_on;
    assign win_pos = pwm_on ? cnt_q : cnt_q - ON_CYC;

    // ==========================================================
    // Samples
    // spikes outside counted span
    always_comb
    begin
        for (int p = 0; p < NPH; p++)
        begin
            phase_o[p].pwm_on = pwm_on;
            phase_o[p].smp_valid = 1'b1;
            phase_o[p].smp = (in_win && win_pos >= `OCG_BLANK_CYC) ? amps_i[p] : SPIKE;
        end
    end
endmodule : ocg_sense_src

// File: sim/tb.sv
/*
 Self-checking bench of the output current fault guard.
 Assumes the sense source model and a retry wait shortened to RETRY cycles.
*/
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int RETRY = 20;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    ocg_pkg::ocg_cmd_t cmd_i = '0;
    logic clear_faults_i = 1'b0;
    logic on_cmd_i = 1'b1;
    logic sense_up_i = 1'b0;
    logic other_fault = 1'b0;
    logic peak_oc = 1'b0;
    logic peak_uc = 1'b0;
    logic signed [15:0] amps [2] = '{16'sh0000, 16'sh0000};
    ocg_pkg::ocg_phase_in_t [1:0] phase;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [7:0] status;
    logic alert_n;
    logic out_en;
    logic oc_trip;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;

    ocg_top #(.NPH(2), .RETRY_CYC(RETRY)) u_dut (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .cmd_i(cmd_i),
        .clear_faults_i(clear_faults_i),
        .on_cmd_i(on_cmd_i),
        .other_fault_i(other_fault),
        .sense_up_i(sense_up_i),
        .phase_i(phase),
        .peak_oc_i(peak_oc),
        .peak_uc_i(peak_uc),
        .rd_data_o(rd_data),
        .rd_valid_o(rd_valid),
        .status_iout_o(status),
        .alert_output_pin_n_o(alert_n),
        .output_en_o(out_en),
        .oc_trip_o(oc_trip)
    );

    ocg_sense_src #(.NPH(2)) u_src (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .sense_up_i(sense_up_i),
        .amps_i(amps),
        .phase_o(phase)
    );

    initial
    begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // ==========================================================
    // Helpers
    task automatic final_report();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // Hang guard: the whole sequence needs well under two thousand cycles
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] cd, input logic [15:0] wd, input logic [15:0] exp);
        @(negedge clk_sys_i);
        cmd_i <= '{valid: 1'b1, write: wr, code: cd, wdata: wd};
        @(negedge clk_sys_i);
        cmd_i <= '0;
        if (!wr)
        begin
            chk("rd_valid", 16'h0001, 16'(rd_valid));
            chk("rd_data", exp, rd_data);
        end
    endtask : bus

    task automatic pulse_clear();
        clear_faults_i = 1'b1;
        @(negedge clk_sys_i);
        clear_faults_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk("status", 16'h0000, 16'(status));
        chk("alert_n", 16'h0001, 16'(alert_n));
    endtask : pulse_clear

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        bus(1'b0, 8'hE6, 16'h0000, 16'h0080);
        bus(1'b0, 8'hE7, 16'h0000, 16'hDA80);
        bus(1'b0, 8'hE8, 16'h0000, 16'hD580);
        bus(1'b0, 8'hE9, 16'h0000, 16'h0000);
        chk("alert_n", 16'h0001, 16'(alert_n));
        chk("out_en", 16'h0001, 16'(out_en));
    endtask : t_reset

    // Spikes outside the counted span must not trip, in both sensing modes
    task automatic t_quiet();
        repeat (80) @(negedge clk_sys_i);
        chk("status", 16'h0000, 16'(status));
        sense_up_i = 1'b1;
        repeat (80) @(negedge clk_sys_i);
        chk("status", 16'h0000, 16'(status));
    endtask : t_quiet

    // Minus 12 A on one phase only, the two-phase mean would stay above the limit
    task automatic t_uc_latch();
        amps[0] = 16'shFF40;
        for (int i = 0; i < 80 && status[4] !== 1'b1; i++) @(negedge clk_sys_i);
        chk("status", 16'h0010, 16'(status));
        chk("alert_n", 16'h0000, 16'(alert_n));
        chk("out_en", 16'h0000, 16'(out_en));
        amps[0] = 16'sh0000;
        repeat (100) @(negedge clk_sys_i);
        chk("status", 16'h0010, 16'(status));
        chk("out_en", 16'h0000, 16'(out_en));
        pulse_clear();
        chk("out_en", 16'h0001, 16'(out_en));
    endtask : t_uc_latch

    // Limit of 5 A with exponent -1, phase 1 at 4 A then 6 A
    task automatic t_oc_lin();
        bus(1'b1, 8'hE7, 16'hF80A, 16'h0000);
        bus(1'b0, 8'hE7, 16'h0000, 16'hF80A);
        amps[1] = 16'sh0040;
        repeat (80) @(negedge clk_sys_i);
        chk("status", 16'h0000, 16'(status));
        amps[1] = 16'sh0060;
        n = 0;
        for (int i = 0; i < 100; i++)
        begin
            @(negedge clk_sys_i);
            n += int'(oc_trip);
        end
        chk("oc_trips", 16'h0001, 16'(n >= 4 && n <= 5));
        chk("status", 16'h0080, 16'(status));
        chk("alert_n", 16'h0000, 16'(alert_n));
        chk("out_en", 16'h0001, 16'(out_en));
        amps[1] = 16'sh0000;
        bus(1'b1, 8'hE7, 16'hDA80, 16'h0000);
        repeat (40) @(negedge clk_sys_i);
        pulse_clear();
    endtask : t_oc_lin

    task automatic t_retry();
        bus(1'b1, 8'hE6, 16'h00B8, 16'h0000);
        bus(1'b0, 8'hE6, 16'h0000, 16'h00B8);
        amps[0] = 16'shFF40;
        for (int i = 0; i < 80 && out_en !== 1'b0; i++) @(negedge clk_sys_i);
        n = 0;
        while (out_en !== 1'b1 && n < 100)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        chk("retry_gap", 16'h0001, 16'(n >= RETRY - 1 && n <= RETRY + 3));
        chk("status", 16'h0010, 16'(status));
        for (int i = 0; i < 80 && out_en !== 1'b0; i++) @(negedge clk_sys_i);
        chk("out_en", 16'h0000, 16'(out_en));
        on_cmd_i = 1'b0;
        amps[0] = 16'sh0000;
        repeat (RETRY + 40) @(negedge clk_sys_i);
        chk("out_en", 16'h0000, 16'(out_en));
        on_cmd_i = 1'b1;
        pulse_clear();
        chk("out_en", 16'h0001, 16'(out_en));
    endtask : t_retry

    // Peak limit pulses share the response; another fault ends the retries
    task automatic t_peak();
        peak_oc = 1'b1;
        peak_uc = 1'b1;
        @(negedge clk_sys_i);
        peak_oc = 1'b0;
        peak_uc = 1'b0;
        chk("oc_trip", 16'h0001, 16'(oc_trip));
        chk("status", 16'h0090, 16'(status));
        chk("out_en", 16'h0000, 16'(out_en));
        other_fault = 1'b1;
        @(negedge clk_sys_i);
        other_fault = 1'b0;
        repeat (RETRY + 10) @(negedge clk_sys_i);
        chk("out_en", 16'h0000, 16'(out_en));
        pulse_clear();
        chk("out_en", 16'h0001, 16'(out_en));
        // Unused behaviour code only reports
        bus(1'b1, 8'hE6, 16'h0000, 16'h0000);
        peak_uc = 1'b1;
        @(negedge clk_sys_i);
        peak_uc = 1'b0;
        chk("status", 16'h0010, 16'(status));
        chk("out_en", 16'h0001, 16'(out_en));
    endtask : t_peak

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (8) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        @(negedge clk_sys_i);
        t_reset();
        t_quiet();
        t_uc_latch();
        sense_up_i = 1'b0;
        t_oc_lin();
        t_retry();
        t_peak();
        final_report();
    end
endmodule : tb

// File: src/ocg_phase_avg.sv
/*
 Per-phase averaging comparator of the output current fault guard.
 Assumes pwm_on and samples come from logic on the same clock.
*/
`include "ocg_regs.svh"

module ocg_phase_avg #(
    parameter int SW = 16,
    parameter int CW = 12,
    parameter int BLANK_CYC = `OCG_BLANK_CYC
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic sense_up_i,
    input wire ocg_pkg::ocg_phase_in_t ph_i,
    input wire logic signed [31:0] oc_lim_i,
    input wire logic signed [31:0] uc_lim_i,
    output logic oc_o,
    output logic uc_o
);

    logic win;
    logic win_q;
    logic [7:0] blank_q;
    logic signed [47:0] sum_q;
    logic [CW-1:0] cnt_q;
    logic signed [47:0] cnt_x;
    logic signed [47:0] oc_prod;
    logic signed [47:0] uc_prod;
    logic win_end;

    // ==========================================================
    // Sensing window
    // Downslope uses off interval
    assign win = sense_up_i ? ph_i.pwm_on : !ph_i.pwm_on;
    assign win_end = win_q && !win;
    assign cnt_x = 48'({1'b0, cnt_q});
    assign oc_prod = 48'(oc_lim_i) * cnt_x;
    assign uc_prod = 48'(uc_lim_i) * cnt_x;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            win_q <= 1'b0;
        else
            win_q <= win;
    end

    // ==========================================================
    // Accumulation, blanking samples skipped
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            blank_q <= 8'h00;
            sum_q <= 48'sh0;
            cnt_q <= '0;
        end
        else if (win && !win_q)
        begin
            blank_q <= 8'(BLANK_CYC);
            sum_q <= 48'sh0;
            cnt_q <= '0;
        end
        else if (win && blank_q != 8'h00)
            blank_q <= blank_q - 8'h01;
        // Count saturates so a very long interval cannot wrap the average
        else if (win && ph_i.smp_valid && cnt_q != '1)
        begin
            sum_q <= sum_q + 48'(ph_i.smp);
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // ==========================================================
    // Compare sum with limit times count, avoiding a divider
    // Once per switching cycle
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            oc_o <= 1'b0;
            uc_o <= 1'b0;
        end
        else
        begin
            oc_o <= win_end && cnt_q != '0 && sum_q > oc_prod;
            uc_o <= win_end && cnt_q != '0 && sum_q < uc_prod;
        end
    end

    a_blank_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        win && win_q && blank_q != 8'h00 |=> $stable(sum_q) && $stable(cnt_q))
        else $error("sample taken in blanking time");

    a_avg_compare: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        win_end && cnt_q != '0 |=> oc_o == ($past(sum_q) > $past(oc_prod))
            && uc_o == ($past(sum_q) < $past(uc_prod)))
        else $error("average compare wrong");

    a_no_mid_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !win_end |=> !oc_o && !uc_o)
        else $error("flag outside interval end");

endmodule : ocg_phase_avg

// File: src/ocg_top.sv
/*
 Output current fault guard: average limits per phase, undercurrent
 response with retry, status bits and alert. Assumes the command front end,
 the sense path and the on command are logic on clk_sys_i.
*/
`include "ocg_regs.svh"

// How it works
// - Behaviour 10 shuts output immediately
// - Undercurrent drives alert low, sets bit
// - Fault bits clear only by clear faults
// - Retry 000 keeps output off until cleared
// - Retry 111 restarts endlessly until stopped
// - Fixed 70 ms between restart attempts
// - Undercurrent response sets undercurrent status bit
// - Action register resets to 80h
// - Overcurrent limit checked per phase
// - Downslope averages off interval past blanking
// - Upslope averages on interval past blanking
// - Average overcurrent shares overcurrent bit, response
// - Average undercurrent shares undercurrent bit, response
// - Limits are Linear-11 amperes
// - Overcurrent limit resets to DA80h
// - Undercurrent limit resets to D580h
module ocg_top #(
    parameter int NPH = 2,
    parameter int RETRY_CYC = `OCG_RETRY_MS * `OCG_CLK_KHZ
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire ocg_pkg::ocg_cmd_t cmd_i,
    input wire logic clear_faults_i,
    input wire logic on_cmd_i,
    input wire logic other_fault_i,
    input wire logic sense_up_i,
    input wire ocg_pkg::ocg_phase_in_t [NPH-1:0] phase_i,
    input wire logic peak_oc_i,
    input wire logic peak_uc_i,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    output logic [7:0] status_iout_o,
    output logic alert_output_pin_n_o,
    output logic output_en_o,
    output logic oc_trip_o
);

    logic [7:0] uc_action_q;
    logic [15:0] avg_oc_lim_q;
    logic [15:0] avg_uc_lim_q;
    logic signed [31:0] oc_fix;
    logic signed [31:0] uc_fix;
    logic [NPH-1:0] oc_hit;
    logic [NPH-1:0] uc_hit;
    logic oc_evt;
    logic uc_evt;
    logic uc_flag_q;
    logic oc_flag_q;
    logic uc_flag_d;
    logic oc_flag_d;
    logic uc_shut;
    logic [1:0] behav;
    logic [2:0] retry;
    ocg_pkg::ocg_state_t state_q;
    logic [31:0] wait_q;

    // ==========================================================
    // Linear-11 to signed fixed point with OCG_SMP_FRAC fraction bits
    function automatic logic signed [31:0] l11_to_fix(input logic [15:0] w);
        logic signed [4:0] n;
        logic signed [31:0] y;
        logic signed [6:0] sh;
        n = w[`OCG_L11_EXP_HI:`OCG_L11_EXP_LO];
        y = 32'($signed(w[`OCG_L11_MAN_HI:`OCG_L11_MAN_LO]));
        sh = 7'(n) + 7'sd`OCG_SMP_FRAC;
        if (sh >= 7'sd0)
            l11_to_fix = y <<< sh;
        else
            l11_to_fix = y >>> (-sh);
    endfunction : l11_to_fix

    assign oc_fix = l11_to_fix(avg_oc_lim_q);
    assign uc_fix = l11_to_fix(avg_uc_lim_q);

    // ==========================================================
    // Per-phase averaging
    generate
        for (genvar p = 0; p < NPH; p++)
        begin : g_phase
            ocg_phase_avg u_avg (
                .clk_sys_i(clk_sys_i),
                .sys_rst_i(sys_rst_i),
                .sense_up_i(sense_up_i),
                .ph_i(phase_i[p]),
                .oc_lim_i(oc_fix),
                .uc_lim_i(uc_fix),
                .oc_o(oc_hit[p]),
                .uc_o(uc_hit[p])
            );
        end
    endgenerate

    assign oc_evt = (|oc_hit) || peak_oc_i;
    assign uc_evt = (|uc_hit) || peak_uc_i;

    // ==========================================================
    // Command registers
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            uc_action_q <= `OCG_UC_ACTION_RST;
            avg_oc_lim_q <= `OCG_AVG_OC_LIM_RST;
            avg_uc_lim_q <= `OCG_AVG_UC_LIM_RST;
        end
        else if (cmd_i.valid && cmd_i.write)
        begin
            case (cmd_i.code)
                `OCG_CMD_UC_ACTION: uc_action_q <= cmd_i.wdata[7:0];
                `OCG_CMD_AVG_OC_LIM: avg_oc_lim_q <= cmd_i.wdata;
                `OCG_CMD_AVG_UC_LIM: avg_uc_lim_q <= cmd_i.wdata;
                default: ;
            endcase
        end
    end

    // Unknown codes read back as zero
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rd_data_o <= 16'h0000;
            rd_valid_o <= 1'b0;
        end
        else
        begin
            rd_valid_o <= cmd_i.valid && !cmd_i.write;
            if (cmd_i.valid && !cmd_i.write)
            begin
                case (cmd_i.code)
                    `OCG_CMD_UC_ACTION: rd_data_o <= {8'h00, uc_action_q};
                    `OCG_CMD_AVG_OC_LIM: rd_data_o <= avg_oc_lim_q;
                    `OCG_CMD_AVG_UC_LIM: rd_data_o <= avg_uc_lim_q;
                    default: rd_data_o <= 16'h0000;
                endcase
            end
        end
    end

    // ==========================================================
    // Sticky status; a new event beats a clear in the same cycle
    always_comb
    begin
        uc_flag_d = uc_flag_q && !clear_faults_i;
        oc_flag_d = oc_flag_q && !clear_faults_i;
        if (uc_evt)
            uc_flag_d = 1'b1;
        if (oc_evt)
            oc_flag_d = 1'b1;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            uc_flag_q <= 1'b0;
            oc_flag_q <= 1'b0;
            status_iout_o <= 8'h00;
            alert_output_pin_n_o <= 1'b1;
            oc_trip_o <= 1'b0;
        end
        else
        begin
            uc_flag_q <= uc_flag_d;
            oc_flag_q <= oc_flag_d;
            status_iout_o <= 8'h00;
            status_iout_o[`OCG_STAT_UC_BIT] <= uc_flag_d;
            status_iout_o[`OCG_STAT_OC_BIT] <= oc_flag_d;
            alert_output_pin_n_o <= !(uc_flag_d || oc_flag_d);
            // Overcurrent response lives with the peak limit logic
            oc_trip_o <= oc_evt;
        end
    end

    // ==========================================================
    // Undercurrent response
    assign behav = uc_action_q[`OCG_BEHAV_HI:`OCG_BEHAV_LO];
    assign retry = uc_action_q[`OCG_RETRY_HI:`OCG_RETRY_LO];
    // Only code 10 shuts down; unused codes only report
    assign uc_shut = uc_evt && behav == `OCG_BEHAV_SHUTDOWN;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= ocg_pkg::OCG_RUN;
            wait_q <= 32'h0;
        end
        else
        begin
            case (state_q)
                ocg_pkg::OCG_RUN:
                begin
                    if (other_fault_i)
                        state_q <= ocg_pkg::OCG_LATCHED;
                    else if (uc_shut && on_cmd_i)
                    begin
                        if (retry == `OCG_RETRY_FOREVER)
                        begin
                            state_q <= ocg_pkg::OCG_RETRY_WAIT;
                            wait_q <= 32'(RETRY_CYC - 1);
                        end
                        // No retry; unused retry codes behave alike
                        else
                            state_q <= ocg_pkg::OCG_LATCHED;
                    end
                end
                ocg_pkg::OCG_LATCHED:
                begin
                    if (clear_faults_i && !other_fault_i)
                        state_q <= ocg_pkg::OCG_RUN;
                end
                ocg_pkg::OCG_RETRY_WAIT:
                begin
                    // Commanded off or other fault ends retries
                    if (other_fault_i)
                        state_q <= ocg_pkg::OCG_LATCHED;
                    else if (!on_cmd_i)
                        state_q <= ocg_pkg::OCG_RUN;
                    else if (wait_q == 32'h0)
                        state_q <= ocg_pkg::OCG_RUN;
                    else
                        wait_q <= wait_q - 32'h1;
                end
                default: state_q <= ocg_pkg::OCG_LATCHED;
            endcase
        end
    end

    // Output dropped in the cycle after the event
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            output_en_o <= 1'b0;
        else
            output_en_o <= state_q == ocg_pkg::OCG_RUN && on_cmd_i && !uc_shut && !other_fault_i;
    end

    // ==========================================================
    // Checks
    sequence s_uc_shut;
        uc_shut && on_cmd_i && !other_fault_i && state_q == ocg_pkg::OCG_RUN;
    endsequence

    sequence s_retry_entry;
        s_uc_shut and retry == `OCG_RETRY_FOREVER;
    endsequence

    a_uc_shutdown: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        uc_shut |=> !output_en_o)
        else $error("output not off after undercurrent");

    a_alert_low: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        uc_evt |=> !alert_output_pin_n_o && status_iout_o[`OCG_STAT_UC_BIT])
        else $error("alert or status missing");

    a_flag_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        uc_flag_q && !clear_faults_i |=> uc_flag_q)
        else $error("fault bit lost without clear");

    a_latched_off: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (s_uc_shut and retry == `OCG_RETRY_NONE) ##1 !clear_faults_i [*3] |=> !output_en_o)
        else $error("output back on without clear");

    a_retry_enter: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        s_retry_entry |=> state_q == ocg_pkg::OCG_RETRY_WAIT && wait_q == 32'(RETRY_CYC - 1))
        else $error("retry not started");

    a_retry_wait: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        state_q == ocg_pkg::OCG_RETRY_WAIT && wait_q != 32'h0 && on_cmd_i && !other_fault_i
            |=> state_q == ocg_pkg::OCG_RETRY_WAIT && wait_q == $past(wait_q) - 32'h1)
        else $error("retry delay broken");

    a_retry_end: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        state_q == ocg_pkg::OCG_RETRY_WAIT && wait_q == 32'h0 && on_cmd_i && !other_fault_i
            |=> state_q == ocg_pkg::OCG_RUN ##1 (output_en_o || $past(uc_shut || other_fault_i || !on_cmd_i)))
        else $error("no restart after delay");

    a_reset_vals: assert property (@(posedge clk_sys_i)
        $fell(sys_rst_i) |-> uc_action_q == `OCG_UC_ACTION_RST
            && avg_oc_lim_q == `OCG_AVG_OC_LIM_RST && avg_uc_lim_q == `OCG_AVG_UC_LIM_RST)
        else $error("register reset value wrong");

    a_oc_status: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (|oc_hit) |=> status_iout_o[`OCG_STAT_OC_BIT] && oc_trip_o)
        else $error("average overcurrent not reported");

    a_uc_status: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (|uc_hit) |=> uc_flag_q)
        else $error("average undercurrent not reported");

endmodule : ocg_top
